/* File: hw/mrf_pkg.sv */
// Package: register map, field layout and carriers for the MAC receive filter and config block
package mrf_pkg;

  // Register word offsets (byte addresses on the bus)
  localparam logic [5:0] RXFC_BASE   = 6'h00;
  localparam logic [5:0] CFG1_BASE   = 6'h10;
  // Alias offsets inside each register group
  localparam logic [1:0] ALIAS_PLAIN = 2'h0;
  localparam logic [1:0] ALIAS_CLR   = 2'h1;
  localparam logic [1:0] ALIAS_SET   = 2'h2;
  localparam logic [1:0] ALIAS_INV   = 2'h3;
  localparam logic [5:0] STAT_ADDR   = 6'h20;

  // Filter configuration fields
  localparam int HASH_EN_BIT   = 15;
  localparam int WAKE_EN_BIT   = 14;
  localparam int PM_INV_BIT    = 12;
  localparam int PM_MODE_LSB   = 8;
  localparam logic [31:0] RXFC_MASK  = 32'h0000_DFFF;
  localparam logic [31:0] RXFC_RESET = 32'h0000_0000;

  // Config-one fields
  localparam int SOFT_RST_BIT  = 15;
  localparam int RNG_RST_BIT   = 14;
  localparam int RX_CS_RST_BIT = 11;
  localparam int RX_FN_RST_BIT = 10;
  localparam int TX_CS_RST_BIT = 9;
  localparam int TX_FN_RST_BIT = 8;
  localparam int LOOPBACK_BIT  = 4;
  localparam int TX_PAUSE_BIT  = 3;
  localparam int RX_PAUSE_BIT  = 2;
  localparam int PASS_ALL_BIT  = 1;
  localparam int RX_ON_BIT     = 0;
  localparam logic [31:0] CFG1_MASK  = 32'h0000_CF1F;
  localparam logic [31:0] CFG1_RESET = 32'h0000_800D;

  // Match modes
  localparam logic [3:0] PM_OFF       = 4'h0;
  localparam logic [3:0] PM_CSUM      = 4'h1;
  localparam logic [3:0] PM_STATION_A = 4'h2;
  localparam logic [3:0] PM_STATION_B = 4'h3;
  localparam logic [3:0] PM_UCAST_A   = 4'h4;
  localparam logic [3:0] PM_UCAST_B   = 4'h5;
  localparam logic [3:0] PM_BCAST_A   = 4'h6;
  localparam logic [3:0] PM_BCAST_B   = 4'h7;
  localparam logic [3:0] PM_HASH      = 4'h8;
  localparam logic [3:0] PM_WAKE      = 4'h9;

  // Per-frame classification from the receive path
  typedef struct packed {
    logic valid;
    logic csum_match;
    logic da_station;
    logic da_unicast;
    logic da_broadcast;
    logic hash_hit;
    logic wake_frame;
    logic control_frame;
    logic pause_frame;
  } mrf_frame_s;

  // Per-frame verdict
  typedef struct packed {
    logic valid;
    logic pattern_ok;
    logic hash_pass;
    logic wake_pass;
    logic accept;
    logic pause_act;
  } mrf_verdict_s;

  // Reset and datapath controls to the MAC
  typedef struct packed {
    logic mac_and_media_interface_rst;
    logic backoff_rng_rst;
    logic rx_cs_rst;
    logic rx_fn_rst;
    logic tx_cs_rst;
    logic tx_fn_rst;
    logic loopback;
    logic tx_pause_allow;
  } mrf_ctrl_s;

endpackage

/* File: hw/mrf_match.sv */
// Combinational pattern-match and acceptance decision for one received frame
`timescale 1ns/1ps
module mrf_match (
  input  wire logic [31:0]              rxfc_i,
  input  wire logic [31:0]              cfg1_i,
  input  wire mrf_pkg::mrf_frame_s      frame_i,
  output mrf_pkg::mrf_verdict_s         verdict_o
);

  logic       inv_csum;
  logic [3:0] mode;
  logic       pm_ok;

  always_comb begin
    inv_csum = rxfc_i[mrf_pkg::PM_INV_BIT] ^ frame_i.csum_match;
    mode     = rxfc_i[mrf_pkg::PM_MODE_LSB +: 4];
    unique case (mode)
      mrf_pkg::PM_OFF:       pm_ok = 1'b0;
      mrf_pkg::PM_CSUM:      pm_ok = inv_csum;
      mrf_pkg::PM_STATION_A,
      mrf_pkg::PM_STATION_B: pm_ok = inv_csum & frame_i.da_station;
      mrf_pkg::PM_UCAST_A,
      mrf_pkg::PM_UCAST_B:   pm_ok = inv_csum & frame_i.da_unicast;
      mrf_pkg::PM_BCAST_A,
      mrf_pkg::PM_BCAST_B:   pm_ok = inv_csum & frame_i.da_broadcast;
      mrf_pkg::PM_HASH:      pm_ok = inv_csum & frame_i.hash_hit;
      mrf_pkg::PM_WAKE:      pm_ok = inv_csum & frame_i.wake_frame;
      // Codes above 1001 are undefined; treat as no match
      default:               pm_ok = 1'b0;
    endcase
    verdict_o.valid      = frame_i.valid;
    verdict_o.pattern_ok = pm_ok;
    verdict_o.hash_pass  = rxfc_i[mrf_pkg::HASH_EN_BIT] & frame_i.hash_hit;
    verdict_o.wake_pass  = rxfc_i[mrf_pkg::WAKE_EN_BIT] & frame_i.wake_frame;
    verdict_o.accept     = cfg1_i[mrf_pkg::RX_ON_BIT]
                         & (cfg1_i[mrf_pkg::PASS_ALL_BIT] | ~frame_i.control_frame);
    verdict_o.pause_act  = cfg1_i[mrf_pkg::RX_ON_BIT] & cfg1_i[mrf_pkg::RX_PAUSE_BIT]
                         & frame_i.pause_frame;
  end

endmodule // mrf_match

/* File: hw/mrf_top.sv */
// Top: Wishbone register file, reset controls and receive verdict for the MAC filter block
// Operation
// - Hash enable gates hash filtering
// - Wake enable gates wake-frame filtering
// - Invert bit flips checksum match sense
// - Mode 0000 disables pattern match
// - Mode 0001 needs checksum condition only
// - Modes 0010/0011 also need station address
// - Modes 0100/0101 also need unicast
// - Modes 0110/0111 also need broadcast
// - Mode 1000 needs hash hit, always evaluated
// - Mode 1001 needs wake frame, always evaluated
// - Soft reset holds MAC, powers up set
// - Simulation reset reloads backoff generator to ACE1
// - Receive sublayer and function resets
// - Transmit sublayer and function resets
// - Loopback routes transmit into receive
// - Transmit pause allow, resets to one
// - Receive pause honour, resets to one
// - Pass-all accepts control frames
// - Receive enable, resets to one
// - 16/32-bit writes taken, 8-bit writes ignored; reads answered for any lanes
`timescale 1ns/1ps
module mrf_top (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone classic slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [5:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // Controller-level receive enable from the surrounding controller
  input  wire logic                  controller_rx_enable_i,
  // Frame classification, transmit path and media receive stream
  input  wire mrf_pkg::mrf_frame_s   frame_i,
  input  wire logic                  mac_tx_valid_i,
  input  wire logic [7:0]            mac_tx_data_i,
  input  wire logic                  mac_tx_pause_i,
  input  wire logic                  phy_rx_valid_i,
  input  wire logic [7:0]            phy_rx_data_i,
  // Outputs
  output mrf_pkg::mrf_verdict_s      verdict_o,
  output mrf_pkg::mrf_ctrl_s         ctrl_o,
  output logic                       phy_tx_valid_o,
  output logic      [7:0]            phy_tx_data_o,
  output logic                       mac_rx_valid_o,
  output logic      [7:0]            mac_rx_data_o,
  output logic      [15:0]           backoff_rand_o
);

  typedef struct packed {
    logic [31:0]           rxfc;
    logic [31:0]           cfg1;
    logic [31:0]           rdata;
    logic                  ack;
    logic                  cfg_wr_denied;
    mrf_pkg::mrf_verdict_s verdict;
    mrf_pkg::mrf_ctrl_s    ctrl;
    logic                  tx_valid;
    logic [7:0]            tx_data;
    logic                  rx_valid;
    logic [7:0]            rx_data;
    logic [15:0]           lfsr;
  } mrf_state_s;

  mrf_state_s            st_reg;
  mrf_state_s            st_next;
  mrf_pkg::mrf_verdict_s verdict_c;

  // Only 16-bit halves and full words count as legal lane patterns
  function automatic logic wide_access(input logic [3:0] sel);
    wide_access = (sel == 4'hF) || (sel == 4'h3) || (sel == 4'hC);
  endfunction

  // Apply a plain, set, clear or invert write on the selected lanes
  function automatic logic [31:0] alias_write(input logic [31:0] cur,
                                              input logic [31:0] wd,
                                              input logic [1:0]  kind,
                                              input logic [3:0]  sel,
                                              input logic [31:0] mask);
    logic [31:0] lanes;
    logic [31:0] res;
    lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & mask;
    unique case (kind)
      mrf_pkg::ALIAS_PLAIN: res = (cur & ~lanes) | (wd & lanes);
      mrf_pkg::ALIAS_CLR:   res = cur & ~(wd & lanes);
      mrf_pkg::ALIAS_SET:   res = cur | (wd & lanes);
      mrf_pkg::ALIAS_INV:   res = cur ^ (wd & lanes);
    endcase
    alias_write = res;
  endfunction

  mrf_match u_match (
    .rxfc_i    (st_reg.rxfc),
    .cfg1_i    (st_reg.cfg1),
    .frame_i   (frame_i),
    .verdict_o (verdict_c)
  );

  logic        req;
  logic        hit_rxfc;
  logic        hit_cfg1;
  logic [1:0]  kind;
  logic        soft_rst;

  always_comb begin
    st_next  = st_reg;
    req      = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    hit_rxfc = (wb_adr_i[5:4] == mrf_pkg::RXFC_BASE[5:4]);
    hit_cfg1 = (wb_adr_i[5:4] == mrf_pkg::CFG1_BASE[5:4]);
    kind     = wb_adr_i[3:2];
    soft_rst = st_reg.cfg1[mrf_pkg::SOFT_RST_BIT];

    // Single-cycle answer; ack drops the cycle after
    st_next.ack = req;
    if (req && !wb_we_i) begin
      if (hit_rxfc) begin
        st_next.rdata = st_reg.rxfc;
      end else if (hit_cfg1) begin
        st_next.rdata = st_reg.cfg1;
      end else if (wb_adr_i == mrf_pkg::STAT_ADDR) begin
        st_next.rdata = {30'h0000_0000, st_reg.cfg_wr_denied, controller_rx_enable_i};
      end else begin
        st_next.rdata = 32'h0000_0000;
      end
    end
    if (req && wb_we_i && wide_access(wb_sel_i)) begin
      if (hit_rxfc) begin
        // Writes with the controller receive enable high are refused and flagged
        if (controller_rx_enable_i) begin
          st_next.cfg_wr_denied = 1'b1;
        end else begin
          st_next.rxfc = alias_write(st_reg.rxfc, wb_dat_i, kind, wb_sel_i,
                                     mrf_pkg::RXFC_MASK);
        end
      end else if (hit_cfg1) begin
        st_next.cfg1 = alias_write(st_reg.cfg1, wb_dat_i, kind, wb_sel_i,
                                   mrf_pkg::CFG1_MASK);
      end else if (wb_adr_i == mrf_pkg::STAT_ADDR && wb_dat_i[1]) begin
        st_next.cfg_wr_denied = 1'b0;
      end
    end

    // Soft reset holds every MAC domain
    st_next.ctrl.mac_and_media_interface_rst = soft_rst;
    st_next.ctrl.backoff_rng_rst = soft_rst | st_reg.cfg1[mrf_pkg::RNG_RST_BIT];
    st_next.ctrl.rx_cs_rst = soft_rst | st_reg.cfg1[mrf_pkg::RX_CS_RST_BIT];
    st_next.ctrl.rx_fn_rst = soft_rst | st_reg.cfg1[mrf_pkg::RX_FN_RST_BIT];
    st_next.ctrl.tx_cs_rst = soft_rst | st_reg.cfg1[mrf_pkg::TX_CS_RST_BIT];
    st_next.ctrl.tx_fn_rst = soft_rst | st_reg.cfg1[mrf_pkg::TX_FN_RST_BIT];
    st_next.ctrl.loopback  = st_reg.cfg1[mrf_pkg::LOOPBACK_BIT];
    st_next.ctrl.tx_pause_allow = st_reg.cfg1[mrf_pkg::TX_PAUSE_BIT];

    if (st_reg.ctrl.backoff_rng_rst) begin
      st_next.lfsr = 16'hACE1;
    end else begin
      st_next.lfsr = {st_reg.lfsr[14:0],
                      st_reg.lfsr[15] ^ st_reg.lfsr[13] ^ st_reg.lfsr[12] ^ st_reg.lfsr[10]};
    end

    // Transmit: blocked pause frames and held function reset emit nothing
    st_next.tx_valid = mac_tx_valid_i & ~st_next.ctrl.tx_fn_rst
                     & (st_reg.ctrl.tx_pause_allow | ~mac_tx_pause_i);
    st_next.tx_data  = mac_tx_data_i;
    // Loopback feeds transmit back to receive
    if (st_reg.ctrl.loopback) begin
      st_next.rx_valid = st_next.tx_valid;
      st_next.rx_data  = mac_tx_data_i;
      st_next.tx_valid = 1'b0;
    end else begin
      st_next.rx_valid = phy_rx_valid_i;
      st_next.rx_data  = phy_rx_data_i;
    end
    if (!st_reg.cfg1[mrf_pkg::RX_ON_BIT] || st_reg.ctrl.rx_fn_rst) begin
      st_next.rx_valid = 1'b0;
    end

    st_next.verdict = verdict_c;
    if (st_reg.ctrl.rx_fn_rst) begin
      st_next.verdict = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg      <= '0;
      st_reg.rxfc <= mrf_pkg::RXFC_RESET;
      st_reg.cfg1 <= mrf_pkg::CFG1_RESET;
      st_reg.ctrl <= 8'hFC;
      st_reg.lfsr <= 16'hACE1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o       = st_reg.rdata;
  assign wb_ack_o       = st_reg.ack;
  assign verdict_o      = st_reg.verdict;
  assign ctrl_o         = st_reg.ctrl;
  assign phy_tx_valid_o = st_reg.tx_valid;
  assign phy_tx_data_o  = st_reg.tx_data;
  assign mac_rx_valid_o = st_reg.rx_valid;
  assign mac_rx_data_o  = st_reg.rx_data;
  assign backoff_rand_o = st_reg.lfsr;

endmodule // mrf_top

/* File: tb/mrf_properties.sv */
// Checker: port-level timing and control properties of mrf_top
`timescale 1ns/1ps
module mrf_properties (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  input wire logic                  mac_tx_valid_i,
  input wire logic [7:0]            mac_tx_data_i,
  input wire logic                  mac_tx_pause_i,
  input wire mrf_pkg::mrf_frame_s   frame_i,
  input wire mrf_pkg::mrf_verdict_s verdict_o,
  input wire mrf_pkg::mrf_ctrl_s    ctrl_o,
  input wire logic                  phy_tx_valid_o,
  input wire logic                  mac_rx_valid_o,
  input wire logic [7:0]            mac_rx_data_o,
  input wire logic [15:0]           backoff_rand_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack not one cycle");
  a_ack_single_pulse: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than a pulse");
  a_soft_holds_all: assert property (
    ctrl_o.mac_and_media_interface_rst |-> ctrl_o.rx_cs_rst && ctrl_o.rx_fn_rst
      && ctrl_o.tx_cs_rst && ctrl_o.tx_fn_rst && ctrl_o.backoff_rng_rst)
    else $error("soft reset not holding domains");
  a_rng_reload: assert property (
    ctrl_o.backoff_rng_rst && $past(ctrl_o.backoff_rng_rst) && !$past(rst_i)
      |-> backoff_rand_o == 16'hACE1) else $error("backoff generator not reloaded");
  a_loop_route: assert property (
    ctrl_o.loopback && $stable(ctrl_o.loopback) && !ctrl_o.tx_fn_rst && !ctrl_o.rx_fn_rst
      && mac_tx_valid_i && !mac_tx_pause_i
      |=> mac_rx_valid_o && mac_rx_data_o == $past(mac_tx_data_i))
    else $error("loopback byte lost");
  a_loop_quiet_phy: assert property (
    ctrl_o.loopback && $stable(ctrl_o.loopback) |=> !phy_tx_valid_o)
    else $error("phy driven in loopback");
  a_pause_blocked: assert property (
    !ctrl_o.tx_pause_allow && $stable(ctrl_o.tx_pause_allow) && mac_tx_valid_i
      && mac_tx_pause_i |=> !phy_tx_valid_o) else $error("pause byte leaked");
  a_verdict_follows: assert property (
    verdict_o.valid |-> $past(frame_i.valid)) else $error("verdict without frame");
  a_pause_needs_frame: assert property (
    verdict_o.pause_act |-> $past(frame_i.pause_frame)) else $error("pause act without pause");
  c_bus_ack: cover property (wb_cyc_i && wb_ack_o);
  c_loopback: cover property (ctrl_o.loopback && mac_tx_valid_i);
  c_pattern_ok: cover property (verdict_o.pattern_ok);
endmodule // mrf_properties

bind mrf_top mrf_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mac_tx_valid_i(mac_tx_valid_i),
  .mac_tx_data_i(mac_tx_data_i), .mac_tx_pause_i(mac_tx_pause_i), .frame_i(frame_i),
  .verdict_o(verdict_o), .ctrl_o(ctrl_o), .phy_tx_valid_o(phy_tx_valid_o),
  .mac_rx_valid_o(mac_rx_valid_o), .mac_rx_data_o(mac_rx_data_o),
  .backoff_rand_o(backoff_rand_o));

/* File: tb/mrf_phy_model.sv */
// Partner: byte-stream stand-in for the media side
`timescale 1ns/1ps
module mrf_phy_model (
  input  wire logic       clk_i,
  input  wire logic       send_i,
  input  wire logic [7:0] byte_i,
  output logic            phy_rx_valid_o,
  output logic [7:0]      phy_rx_data_o
);
  initial begin
    phy_rx_valid_o = 1'b0;
    phy_rx_data_o = 8'h00;
  end
  always @(posedge clk_i) begin
    phy_rx_valid_o <= send_i;
    // Idle line toggles so a stale byte never passes for data
    phy_rx_data_o <= send_i ? byte_i : ~phy_rx_data_o;
  end
endmodule // mrf_phy_model

/* File: tb/mrf_top_bench.sv */
// Bench: register, verdict and stream checks for mrf_top
`timescale 1ns/1ps
module mrf_top_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic crx = 1'b0;
  logic send = 1'b0;
  logic tv = 1'b0;
  logic tp = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'hF;
  logic [7:0] td = 8'h00;
  logic [7:0] sb = 8'h00;
  logic [31:0] dw = 32'h0000_0000;
  logic [31:0] dr, rv;
  logic ack, ptv, prv, mrv;
  logic [7:0] ptd, prd, mrd;
  logic [15:0] rnd;
  mrf_pkg::mrf_frame_s fr = 9'h000;
  mrf_pkg::mrf_verdict_s vd;
  mrf_pkg::mrf_ctrl_s ct;
  int n_errors = 0;
  int samples_checked = 0;
  int ticks = 0;
  always #20 clk_i = ~clk_i;
  mrf_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .controller_rx_enable_i(crx), .frame_i(fr), .mac_tx_valid_i(tv), .mac_tx_data_i(td),
    .mac_tx_pause_i(tp), .phy_rx_valid_i(prv), .phy_rx_data_i(prd), .verdict_o(vd),
    .ctrl_o(ct), .phy_tx_valid_o(ptv), .phy_tx_data_o(ptd), .mac_rx_valid_o(mrv),
    .mac_rx_data_o(mrd), .backoff_rand_o(rnd));
  mrf_phy_model phy (.clk_i(clk_i), .send_i(send), .byte_i(sb), .phy_rx_valid_o(prv),
    .phy_rx_data_o(prd));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dw <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rv = dr;
    cyc <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 4'hF, 32'h0000_0000);
    chk(nm, e, rv);
  endtask
  task automatic mtx(input logic [7:0] d, input logic p);
    @(posedge clk_i);
    tv <= 1'b1;
    td <= d;
    tp <= p;
    @(posedge clk_i);
    tv <= 1'b0;
    #1;
  endtask
  function automatic logic pm_exp(input logic [3:0] m, input logic i,
                                  input mrf_pkg::mrf_frame_s f);
    logic c;
    c = i ^ f.csum_match;
    case (m)
      4'h1: return c;
      4'h2, 4'h3: return c & f.da_station;
      4'h4, 4'h5: return c & f.da_unicast;
      4'h6, 4'h7: return c & f.da_broadcast;
      4'h8: return c & f.hash_hit;
      4'h9: return c & f.wake_frame;
      default: return 1'b0;
    endcase
  endfunction
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic frm(input mrf_pkg::mrf_frame_s f);
    @(posedge clk_i);
    fr <= f;
    @(posedge clk_i);
    fr <= 9'h000;
    #1;
  endtask
  initial begin
    mrf_pkg::mrf_frame_s f;
    logic [5:0]          ev;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(6'h10, 32'h0000_800D, "cfg1");
    rd(6'h00, 32'h0000_0000, "rxfc");
    chk("ctrl", 32'h0000_00FD, {24'h0, ct});
    wb(1'b1, 6'h10, 4'hF, 32'h0000_0000);
    rd(6'h10, 32'h0000_0000, "cfg1");
    chk("ctrl", 32'h0000_0000, {24'h0, ct});
    wb(1'b1, 6'h18, 4'hF, 32'hFFFF_FFFF);
    rd(6'h10, 32'h0000_CF1F, "cfg1");
    chk("ctrl", 32'h0000_00FF, {24'h0, ct});
    chk("rng", 32'h0000_ACE1, {16'h0, rnd});
    wb(1'b1, 6'h14, 4'hF, 32'h0000_8000);
    // Control outputs follow the register one cycle late
    @(posedge clk_i);
    chk("ctrl", 32'h0000_007F, {24'h0, ct});
    wb(1'b1, 6'h1C, 4'hF, 32'h0000_4F00);
    rd(6'h10, 32'h0000_001F, "cfg1");
    chk("ctrl", 32'h0000_0003, {24'h0, ct});
    // Byte lane refused, low half taken
    wb(1'b1, 6'h10, 4'h1, 32'h0000_0000);
    rd(6'h10, 32'h0000_001F, "cfg1");
    wb(1'b1, 6'h10, 4'h3, 32'hFFFF_0005);
    rd(6'h10, 32'h0000_0005, "cfg1");
    crx <= 1'b1;
    wb(1'b1, 6'h00, 4'hF, 32'hFFFF_FFFF);
    rd(6'h00, 32'h0000_0000, "rxfc");
    rd(6'h20, 32'h0000_0003, "stat");
    crx <= 1'b0;
    wb(1'b1, 6'h20, 4'hF, 32'h0000_0002);
    rd(6'h20, 32'h0000_0000, "stat");
    wb(1'b1, 6'h00, 4'hF, 32'hFFFF_FFFF);
    rd(6'h00, 32'h0000_DFFF, "rxfc");
    rd(6'h24, 32'h0000_0000, "hole");
    // Every mode, both senses; filter enables follow the sense bit
    for (int m = 0; m < 16; m++) begin
      for (int k = 0; k < 4; k++) begin
        wb(1'b1, 6'h00, 4'hF, {16'h0, k[0], k[0], 1'b0, k[0], m[3:0], 8'h00});
        f = k[1] ? 9'h117 : 9'h1E8;
        frm(f);
        chk("pattern", {31'h0, pm_exp(m[3:0], k[0], f)}, {31'h0, vd.pattern_ok});
        ev = {1'b1, pm_exp(m[3:0], k[0], f), k[0] & f.hash_hit, k[0] & f.wake_frame,
              ~f.control_frame, f.pause_frame};
        chk("verdict", {26'h0, ev}, {26'h0, vd});
      end
    end
    wb(1'b1, 6'h10, 4'hF, 32'h0000_0015);
    rd(6'h10, 32'h0000_0015, "cfg1");
    mtx(8'hA5, 1'b0);
    chk("loop", 32'h0000_01A5, {23'h0, mrv, mrd});
    chk("phyq", 32'h0000_0000, {31'h0, ptv});
    wb(1'b1, 6'h10, 4'hF, 32'h0000_000D);
    rd(6'h10, 32'h0000_000D, "cfg1");
    mtx(8'h3C, 1'b1);
    chk("ptx", 32'h0000_013C, {23'h0, ptv, ptd});
    wb(1'b1, 6'h10, 4'hF, 32'h0000_0005);
    rd(6'h10, 32'h0000_0005, "cfg1");
    mtx(8'h3C, 1'b1);
    chk("pblk", 32'h0000_0000, {31'h0, ptv});
    mtx(8'h5A, 1'b0);
    chk("ptx", 32'h0000_015A, {23'h0, ptv, ptd});
    @(posedge clk_i);
    send <= 1'b1;
    sb <= 8'hC3;
    @(posedge clk_i);
    send <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("mrx", 32'h0000_01C3, {23'h0, mrv, mrd});
    // Pass-all lets a control frame through
    wb(1'b1, 6'h10, 4'hF, 32'h0000_0007);
    frm(9'h117);
    chk("verdict", 32'h0000_0027, {26'h0, vd});
    // Receive off: nothing accepted, stream blocked
    wb(1'b1, 6'h10, 4'hF, 32'h0000_0000);
    frm(9'h117);
    chk("verdict", 32'h0000_0024, {26'h0, vd});
    @(posedge clk_i);
    send <= 1'b1;
    sb <= 8'h99;
    @(posedge clk_i);
    send <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("mrxoff", 32'h0000_0000, {31'h0, mrv});
    give_verdict();
  end
endmodule // mrf_top_bench
